//--- bench/config_prom_readout_control_tb.sv
`timescale 1ns/1ps
module config_prom_readout_control_tb;
  localparam int unsigned AW = 4;
  localparam logic [AW-1:0] LAST_ADDR = 4'h5;
  localparam int unsigned POR = 20;
  logic i_clock, i_sys_rst, oe_pin, cs_n, low_v, mem_bit, cfg_clk, oe_wire, b;
  logic rst_out, rst_oe, data, data_oe, chain_n, standby;
  logic [AW-1:0] addr;
  int err_count = 0;
  int samples_checked = 0;
  // clock and pins at time zero; oe pin pulled high by its resistor
  initial begin
    i_clock = 1'b0;
    i_sys_rst = 1'b1;
    oe_pin = 1'b1;
    cs_n = 1'b0;
    low_v = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // open-drain oe/reset wire; memory bit pattern is cheap to predict
  assign oe_wire = rst_oe ? rst_out : oe_pin;
  assign mem_bit = addr[0] ^ addr[2];
  cpr_readout #(.ADDR_W(AW), .TERMINAL_COUNT(LAST_ADDR), .POR_CYCLES(POR)) dut_u (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_oe_reset(oe_wire),
    .i_chip_select_n(cs_n), .i_config_clock(cfg_clk), .i_supply_low(low_v),
    .i_mem_bit(mem_bit), .o_oe_reset_out(rst_out), .o_oe_reset_oe(rst_oe),
    .o_mem_addr(addr), .o_serial_data_out(data), .o_serial_data_oe(data_oe),
    .o_chain_select_out_n(chain_n), .o_standby(standby));
  cpr_cfg_port_model partner_u (
    .i_clock(i_clock), .i_data(data), .i_data_oe(data_oe), .o_config_clock(cfg_clk));
  task automatic chk(input string name, input logic [AW-1:0] exp, input logic [AW-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  // pins move on a falling edge; four cycles covers the three-edge pin latency
  task automatic set_pins(input logic oe, input logic cs, input logic lv);
    @(negedge i_clock);
    oe_pin = oe;
    cs_n = cs;
    low_v = lv;
    repeat (4) @(negedge i_clock);
  endtask
  task automatic t_power_up();
    repeat (4) @(negedge i_clock);
    i_sys_rst = 1'b0;
    repeat (POR / 2) @(negedge i_clock);
    chk("hold_oe", 4'h1, {3'h0, rst_oe});
    chk("hold_out", 4'h0, {3'h0, rst_out});
    chk("hold_data_oe", 4'h0, {3'h0, data_oe});
    repeat (POR) @(negedge i_clock);
    chk("hold_end", 4'h0, {3'h0, rst_oe});
    chk("oe_hi_chain", 4'h1, {3'h0, chain_n});
    chk("oe_hi_standby", 4'h0, {3'h0, standby});
  endtask
  // full readout up to and past the terminal count
  task automatic t_read_out();
    logic [AW-1:0] k;
    set_pins(1'b0, 1'b0, 1'b0);
    chk("first_oe", 4'h1, {3'h0, data_oe});
    chk("first_addr", 4'h0, addr);
    chk("first_bit", 4'h0, {3'h0, data});
    for (k = 4'h1; k <= LAST_ADDR; k++) begin
      partner_u.pulse(b);
      chk("count_addr", k, addr);
      chk("count_bit", {3'h0, k[0] ^ k[2]}, {3'h0, b});
      chk("count_chain", 4'h1, {3'h0, chain_n});
    end
    partner_u.pulse(b);
    chk("wrap_addr", 4'h0, addr);
    chk("last_chain", 4'h0, {3'h0, chain_n});
    chk("last_data_oe", 4'h0, {3'h0, data_oe});
    partner_u.pulse(b);
    chk("done_addr", 4'h0, addr);
    chk("done_chain", 4'h0, {3'h0, chain_n});
  endtask
  task automatic t_oe_reset();
    set_pins(1'b1, 1'b0, 1'b0);
    chk("oe_hi_chain", 4'h1, {3'h0, chain_n});
    chk("oe_hi_data_oe", 4'h0, {3'h0, data_oe});
    partner_u.pulse(b);
    chk("oe_hi_addr", 4'h0, addr);
    set_pins(1'b0, 1'b0, 1'b0);
    partner_u.pulse(b);
    partner_u.pulse(b);
    chk("restart_addr", 4'h2, addr);
  endtask
  task automatic t_standby();
    set_pins(1'b0, 1'b1, 1'b0);
    chk("sb_flag", 4'h1, {3'h0, standby});
    chk("sb_addr", 4'h0, addr);
    chk("sb_chain", 4'h1, {3'h0, chain_n});
    chk("sb_data_oe", 4'h0, {3'h0, data_oe});
    set_pins(1'b1, 1'b1, 1'b0);
    chk("sb_oe_hi", 4'h0, {3'h0, data_oe});
    set_pins(1'b0, 1'b1, 1'b0);
    partner_u.pulse(b);
    chk("sb_clk_addr", 4'h0, addr);
    chk("sb_clk_oe", 4'h0, {3'h0, data_oe});
  endtask
  // brown-out in mid-read restarts the whole power-up hold
  task automatic t_brown_out();
    set_pins(1'b0, 1'b0, 1'b0);
    partner_u.pulse(b);
    chk("pre_addr", 4'h1, addr);
    set_pins(1'b0, 1'b0, 1'b1);
    chk("bo_hold", 4'h1, {3'h0, rst_oe});
    chk("bo_addr", 4'h0, addr);
    set_pins(1'b0, 1'b0, 1'b0);
    chk("bo_still", 4'h1, {3'h0, rst_oe});
    repeat (POR) @(negedge i_clock);
    chk("bo_release", 4'h0, {3'h0, rst_oe});
    // the core lets its own released pull-down drain from the synchroniser first
    repeat (4) @(negedge i_clock);
    chk("bo_data_oe", 4'h1, {3'h0, data_oe});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    t_power_up();
    t_read_out();
    t_oe_reset();
    t_standby();
    t_brown_out();
    end_of_test();
  end
  // the sequence needs well under 1000 cycles
  initial begin
    #20000;
    err_count++;
    end_of_test();
  end
endmodule

//--- bench/cpr_cfg_port_model.sv
`timescale 1ns/1ps
// stand-in for the configuration port that clocks the memory and reads its data
module cpr_cfg_port_model (
  input wire logic i_clock,
  input wire logic i_data,
  input wire logic i_data_oe,
  output logic o_config_clock
);
  logic last_bit;
  initial begin
    o_config_clock = 1'b0;
    last_bit = 1'b0;
  end
  // three cycles high, three low so the synchroniser sees both levels; stands low between
  task automatic pulse(output logic bit_seen);
    @(negedge i_clock);
    o_config_clock = 1'b1;
    repeat (3) @(negedge i_clock);
    o_config_clock = 1'b0;
    repeat (3) @(negedge i_clock);
    // a floating data line shows the inverse of its last value
    bit_seen = i_data_oe ? i_data : ~last_bit;
    last_bit = bit_seen;
  endtask
endmodule

//--- logic/cpr_pin_sync.sv
`timescale 1ns/1ps
module cpr_pin_sync (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_oe_reset,
  input wire logic i_chip_select_n,
  input wire logic i_supply_low,
  input wire logic i_config_clock,
  cpr_pins_if.src pins
);

  typedef struct packed {
    logic [cpr_pkg::PIN_COUNT-1:0] meta;
    logic [cpr_pkg::PIN_COUNT-1:0] sync;
    logic clk_prev;
  } cpr_sync_t;

  cpr_sync_t s_q;
  cpr_sync_t s_d;
  logic [cpr_pkg::PIN_COUNT-1:0] raw;

  assign raw[cpr_pkg::PIN_OE] = i_oe_reset;
  assign raw[cpr_pkg::PIN_CS] = i_chip_select_n;
  assign raw[cpr_pkg::PIN_LOWV] = i_supply_low;
  assign raw[cpr_pkg::PIN_CFG_CLK] = i_config_clock;

  // two flops per pin; the edge detector only looks at the second stage
  always_comb begin
    s_d = s_q;
    s_d.meta = raw;
    s_d.sync = s_q.meta;
    s_d.clk_prev = s_q.sync[cpr_pkg::PIN_CFG_CLK];
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins.oe_level = s_q.sync[cpr_pkg::PIN_OE];
  assign pins.cs_level = s_q.sync[cpr_pkg::PIN_CS];
  assign pins.supply_low = s_q.sync[cpr_pkg::PIN_LOWV];
  // config clock rising edge, one system cycle wide
  assign pins.clk_rise = s_q.sync[cpr_pkg::PIN_CFG_CLK] & ~s_q.clk_prev;

endmodule

//--- logic/cpr_pins_if.sv
`timescale 1ns/1ps
interface cpr_pins_if;
  logic oe_level;
  logic cs_level;
  logic supply_low;
  logic clk_rise;

  modport src (output oe_level, output cs_level, output supply_low, output clk_rise);
  modport dst (input oe_level, input cs_level, input supply_low, input clk_rise);
endinterface

//--- logic/cpr_pkg.sv
package cpr_pkg;

  // system clock rate
  localparam int unsigned CLOCK_MHZ = 250;

  // power-up hold of the output-enable/reset line, in ms, and in cycles (exact integer product, no rounding)
  localparam int unsigned POR_HOLD_MS = 1;
  localparam int unsigned POR_HOLD_CYCLES = POR_HOLD_MS * 1000 * CLOCK_MHZ;

  // default width of the internal bit address counter
  localparam int unsigned ADDR_W_DEF = 16;

  // address value that follows the terminal count
  localparam int unsigned ADDR_WRAP = 0;

  // synchroniser depth: cycles before a pin level reaches the core
  localparam int unsigned SYNC_SETTLE = 2;

  // positions of the synchronised pins inside the sync bank
  localparam int unsigned PIN_OE = 0;
  localparam int unsigned PIN_CS = 1;
  localparam int unsigned PIN_LOWV = 2;
  localparam int unsigned PIN_CFG_CLK = 3;
  localparam int unsigned PIN_COUNT = 4;

  // readout control states, one-hot
  typedef enum logic [4:0] {
    ST_POR = 5'h01,
    ST_IDLE = 5'h02,
    ST_STANDBY = 5'h04,
    ST_READ = 5'h08,
    ST_DONE = 5'h10
  } cpr_state_t;

endpackage

//--- logic/cpr_readout.sv
`timescale 1ns/1ps
// Operation
// - oe and cs low: count to terminal count, then hold, float, chain out low.
// - terminal count is highest address; the address after it is zero.
// - chip-select high enters standby and holds the address reset.
// - in standby the data output floats regardless of output-enable.
// - after power-up drive output-enable/reset low about 1 ms before delivering data.
// - supply below 2.0 volts returns to reset and clears the address counter.
// - clock after the last bit drives chain out low and disables data.
// - address and bit counters advance on every valid config clock rising edge.
module cpr_readout #(
  parameter int unsigned ADDR_W = cpr_pkg::ADDR_W_DEF,
  parameter logic [ADDR_W-1:0] TERMINAL_COUNT = '1,
  parameter int unsigned POR_CYCLES = cpr_pkg::POR_HOLD_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_oe_reset,
  input wire logic i_chip_select_n,
  input wire logic i_config_clock,
  input wire logic i_supply_low,
  input wire logic i_mem_bit,
  output logic o_oe_reset_out,
  output logic o_oe_reset_oe,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic o_serial_data_out,
  output logic o_serial_data_oe,
  output logic o_chain_select_out_n,
  output logic o_standby
);

  localparam int unsigned CNT_W = $clog2(POR_CYCLES + 1);
  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYCLES - 1);
  localparam logic [ADDR_W-1:0] ADDR_ZERO = ADDR_W'(cpr_pkg::ADDR_WRAP);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(cpr_pkg::SYNC_SETTLE);

  typedef struct packed {
    cpr_pkg::cpr_state_t state;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0] por_cnt;
    logic data;
    logic data_oe;
    logic chain_n;
    logic standby;
    logic oe_drive;
    logic oe_out;
  } cpr_core_t;

  localparam cpr_core_t CORE_RST = '{
    state: cpr_pkg::ST_POR,
    addr: ADDR_ZERO,
    por_cnt: '0,
    data: 1'b0,
    data_oe: 1'b0,
    chain_n: 1'b1,
    standby: 1'b0,
    oe_drive: 1'b1,
    oe_out: 1'b0
  };

  cpr_pins_if pins ();

  cpr_pin_sync u_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_oe_reset(i_oe_reset),
    .i_chip_select_n(i_chip_select_n),
    .i_supply_low(i_supply_low),
    .i_config_clock(i_config_clock),
    .pins(pins.src)
  );

  cpr_core_t s_q;
  cpr_core_t s_d;

  // next state; brown-out beats everything, the power-up hold ignores every pin but supply-low
  always_comb begin
    s_d = s_q;
    if (pins.supply_low) begin
      s_d.state = cpr_pkg::ST_POR;
      s_d.addr = ADDR_ZERO;
      s_d.por_cnt = '0;
    end else begin
      unique case (s_q.state)
        cpr_pkg::ST_IDLE, cpr_pkg::ST_STANDBY, cpr_pkg::ST_READ, cpr_pkg::ST_DONE: begin
          if (pins.cs_level) begin
            s_d.state = cpr_pkg::ST_STANDBY;
            s_d.addr = ADDR_ZERO;
          end else if (pins.oe_level) begin
            s_d.state = cpr_pkg::ST_IDLE;
            s_d.addr = ADDR_ZERO;
          end else if (s_q.state == cpr_pkg::ST_READ) begin
            if (pins.clk_rise) begin
              if (s_q.addr == TERMINAL_COUNT) begin
                s_d.addr = ADDR_ZERO;
                s_d.state = cpr_pkg::ST_DONE;
              end else begin
                s_d.addr = s_q.addr + 1'b1;
              end
            end
          end else if (s_q.state == cpr_pkg::ST_IDLE && s_q.por_cnt < SETTLE_LAST) begin
            // just out of the power-up hold our own pull-down is still in the
            // synchroniser; a low oe level is not trusted until it has drained
            s_d.por_cnt = s_q.por_cnt + 1'b1;
          end else if (s_q.state != cpr_pkg::ST_DONE) begin
            // leaving reset hold: first bit sits at address zero before any clock
            s_d.state = cpr_pkg::ST_READ;
          end
        end
        default: begin
          // power-up hold; also catches an illegal state code
          s_d.state = cpr_pkg::ST_POR;
          s_d.addr = ADDR_ZERO;
          if (s_q.por_cnt >= POR_LAST) begin
            s_d.state = cpr_pkg::ST_IDLE;
            s_d.por_cnt = '0;
          end else begin
            s_d.por_cnt = s_q.por_cnt + 1'b1;
          end
        end
      endcase
    end
    // pin outputs follow the next state so they line up with the state flop
    s_d.data_oe = (s_d.state == cpr_pkg::ST_READ);
    // memory read lags the address by one cycle; data is the bit at the address held one cycle earlier
    s_d.data = s_d.data_oe & i_mem_bit;
    s_d.chain_n = (s_d.state != cpr_pkg::ST_DONE);
    s_d.standby = (s_d.state == cpr_pkg::ST_STANDBY);
    s_d.oe_drive = (s_d.state == cpr_pkg::ST_POR);
    s_d.oe_out = 1'b0; // open-drain: only ever pulls low
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      s_q <= CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_oe_reset_out = s_q.oe_out;
  assign o_oe_reset_oe = s_q.oe_drive;
  assign o_mem_addr = s_q.addr;
  assign o_serial_data_out = s_q.data;
  assign o_serial_data_oe = s_q.data_oe;
  assign o_chain_select_out_n = s_q.chain_n;
  assign o_standby = s_q.standby;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // a selected read step with no pin change pending
  sequence s_read_step;
    s_q.state == cpr_pkg::ST_READ && pins.clk_rise && !pins.cs_level
      && !pins.oe_level && !pins.supply_low;
  endsequence

  sequence s_last_step;
    s_read_step ##0 s_q.addr == TERMINAL_COUNT;
  endsequence

  a_count_step: assert property (
    s_read_step ##0 s_q.addr != TERMINAL_COUNT |=> s_q.addr == $past(s_q.addr) + 1'b1
      && o_serial_data_oe && o_chain_select_out_n)
    else $error("address did not advance on config clock edge");

  a_count_wrap: assert property (
    s_last_step |=> s_q.addr == ADDR_ZERO)
    else $error("address after terminal count is not zero");

  a_chain_handover: assert property (
    s_last_step |=> !o_chain_select_out_n && !o_serial_data_oe)
    else $error("chain out not low after last bit");

  a_done_holds: assert property (
    s_q.state == cpr_pkg::ST_DONE && !pins.cs_level && !pins.oe_level && !pins.supply_low
      |=> $stable(s_q.addr) && !o_chain_select_out_n)
    else $error("address moved past terminal count");

  a_standby_entry: assert property (
    pins.cs_level && !pins.supply_low && s_q.state != cpr_pkg::ST_POR
      |=> o_standby && s_q.addr == ADDR_ZERO && o_chain_select_out_n)
    else $error("chip select high did not enter standby");

  a_standby_float: assert property (
    o_standby |-> !o_serial_data_oe)
    else $error("data driven in standby");

  a_oe_hold: assert property (
    pins.oe_level && !pins.cs_level && !pins.supply_low && s_q.state != cpr_pkg::ST_POR
      |=> s_q.addr == ADDR_ZERO && !o_serial_data_oe && o_chain_select_out_n && !o_standby)
    else $error("output enable high did not hold reset");

  a_por_drive: assert property (
    $fell(i_sys_rst) |-> (o_oe_reset_oe && !o_oe_reset_out && !o_serial_data_oe) [*8])
    else $error("reset line not held after power-up");

  a_por_quiet: assert property (
    s_q.state == cpr_pkg::ST_POR |-> o_oe_reset_oe && !o_serial_data_oe && !o_standby)
    else $error("data or standby during power-up hold");

  a_brownout: assert property (
    pins.supply_low |=> s_q.state == cpr_pkg::ST_POR && s_q.addr == ADDR_ZERO
      && o_oe_reset_oe ##1 o_oe_reset_oe)
    else $error("brown-out did not reset the counter");

  a_brownout_float: assert property (
    pins.supply_low |=> !o_serial_data_oe && o_chain_select_out_n && !o_standby)
    else $error("outputs not in reset state during brown-out");

  // first cycle out of the power-up hold
  sequence s_hold_exit;
    s_q.state == cpr_pkg::ST_POR ##1 s_q.state == cpr_pkg::ST_IDLE;
  endsequence

  a_settle_quiet: assert property (
    s_hold_exit |-> !o_serial_data_oe [*3])
    else $error("data driven before the released reset line settled");

  a_read_active: assert property (
    s_d.state == cpr_pkg::ST_READ |=> o_serial_data_oe && o_chain_select_out_n
      && o_serial_data_out == $past(i_mem_bit))
    else $error("read data not driven from the addressed bit");

endmodule
